// ===== uv_stall_pkg.sv
// Constants shared by the under-voltage and blocked-rotor monitor
package uv_stall_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET     = 8'h00;
    localparam logic [7:0] LIMITS_OFFSET   = 8'h04;
    localparam logic [7:0] STATUS1_OFFSET  = 8'h08;
    localparam logic [7:0] STATUS4_OFFSET  = 8'h0C;

    // Control register fields
    localparam int CTRL_MOTOR_EN_BIT   = 0;
    localparam int CTRL_ENH_BIT        = 1;
    localparam int CTRL_L1_IRQ_BIT     = 2;
    localparam int CTRL_L2_IRQ_BIT     = 3;
    localparam int CTRL_L2_MASK_BIT    = 4;
    localparam int CTRL_L3_IRQ_BIT     = 5;
    localparam int CTRL_L3_MASK_BIT    = 6;
    localparam int CTRL_WIDTH          = 7;
    localparam logic [6:0] CTRL_RESET  = 7'h00;

    // Limits register fields
    localparam int LIM_UV_INDEX_LSB    = 0;
    localparam int LIM_STALL_THR_LSB   = 8;
    localparam int LIM_TIMEOUT_LSB     = 16;
    localparam int LIM_SPEED_LSB       = 24;
    localparam logic [31:0] LIMITS_RESET = 32'h0000_0000;

    // Status 1 fields
    localparam int ST1_STALL_BIT       = 0;
    localparam int ST1_UV1_BIT         = 1;
    localparam int ST1_UV2_BIT         = 2;
    localparam int ST1_UV3_BIT         = 3;
    localparam int ST1_LOST_BIT        = 4;
    localparam int ST1_LOCK_BIT        = 5;

    // Status 4 fields
    localparam int ST4_CODE_LSB        = 0;
    localparam int ST4_SIGN_BIT        = 5;
    localparam int ST4_COIL_BIT        = 6;
    localparam int ST4_READY_BIT       = 7;
    localparam int ST4_LOST_LSB        = 8;

    // Counts
    localparam logic [6:0] LOST_MAX        = 7'h7F;
    localparam int         TICKS_PER_UNIT  = 4;
    localparam logic [1:0] STALL_RUNS      = 2'h2;

endpackage : uv_stall_pkg

// ===== sync2.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
module sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         arst_n_i,
    input  wire logic         ce_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_reg <= '0;
            q_o      <= '0;
        end
        else if (ce_i)
        begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end

endmodule : sync2

// ===== undervoltage_and_stall_monitor.sv
// Under-voltage reaction, lost-step counting and back-EMF blocked-rotor detection
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module undervoltage_and_stall_monitor (
    // Clock, reset, enable
    input  wire logic        core_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        ce_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // Supply comparators, asynchronous
    input  wire logic        level1_supply_low_i,
    input  wire logic        level2_supply_low_i,
    input  wire logic        level3_supply_low_i,
    output logic      [3:0]  undervolt_threshold_index_o,
    // Step and direction pins, asynchronous
    input  wire logic        step_pulse_i,
    input  wire logic        direction_i,
    output logic             step_exec_o,
    output logic             stall_back_step_o,
    // Motion state from translator logic
    input  wire logic        run_mode_i,
    input  wire logic        hold_full_step_i,
    input  wire logic [3:0]  hold_current_setting_i,
    input  wire logic [7:0]  measured_speed_i,
    // Back-EMF sampling front end
    input  wire logic        pwm_tick_i,
    input  wire logic        zero_cross_i,
    input  wire logic        sample_valid_i,
    input  wire logic [4:0]  sample_code_i,
    input  wire logic        sample_sign_i,
    input  wire logic        sample_coil_i,
    input  wire logic        other_coil_pwm_on_i,
    // Bridge and error line
    output logic             motor_enable_o,
    output logic             error_line_n_o,
    output logic             error_line_oe_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronised pins

    logic [4:0] pins_sync;
    logic       uv1_live;
    logic       uv2_live;
    logic       uv3_live;
    logic       step_sync;
    logic       dir_sync;
    logic       step_d_reg;
    logic       dir_d_reg;
    logic       step_edge;
    logic       dir_change;

    sync2 #(.W(5)) u_pin_sync (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .ce_i       (ce_i),
        .d_i        ({direction_i, step_pulse_i, level3_supply_low_i,
                      level2_supply_low_i, level1_supply_low_i}),
        .q_o        (pins_sync)
    );

    assign uv1_live  = pins_sync[0];
    assign uv2_live  = pins_sync[1];
    assign uv3_live  = pins_sync[2];
    assign step_sync = pins_sync[3];
    assign dir_sync  = pins_sync[4];

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            step_d_reg <= 1'b0;
            dir_d_reg  <= 1'b0;
        end
        else if (ce_i)
        begin
            step_d_reg <= step_sync;
            dir_d_reg  <= dir_sync;
        end
    end

    assign step_edge  = step_sync & ~step_d_reg;
    assign dir_change = dir_sync ^ dir_d_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode

    logic [6:0]  ctrl_reg;
    logic [31:0] limits_reg;
    logic        wr_ctrl;
    logic        wr_limits;
    logic        rd_st1;
    logic        rd_st4;
    logic [3:0]  stall_thr;
    logic [7:0]  timeout;
    logic [7:0]  speed_limit;
    logic        enhanced;

    assign wr_ctrl   = wr_i & (addr_i == uv_stall_pkg::CTRL_OFFSET);
    assign wr_limits = wr_i & (addr_i == uv_stall_pkg::LIMITS_OFFSET);
    assign rd_st1    = rd_i & (addr_i == uv_stall_pkg::STATUS1_OFFSET);
    assign rd_st4    = rd_i & (addr_i == uv_stall_pkg::STATUS4_OFFSET);

    assign stall_thr   = limits_reg[uv_stall_pkg::LIM_STALL_THR_LSB +: 4];
    assign timeout     = limits_reg[uv_stall_pkg::LIM_TIMEOUT_LSB +: 8];
    assign speed_limit = limits_reg[uv_stall_pkg::LIM_SPEED_LSB +: 8];
    assign enhanced    = ctrl_reg[uv_stall_pkg::CTRL_ENH_BIT];
    assign undervolt_threshold_index_o = limits_reg[uv_stall_pkg::LIM_UV_INDEX_LSB +: 4];

    ////////////////////////////////////////////////////////////////////////////////
    // Under-voltage flags and motor enable

    logic uv1_flag_reg;
    logic uv2_flag_reg;
    logic uv3_flag_reg;
    logic motor_en_reg;

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            uv1_flag_reg <= 1'b0;
            uv2_flag_reg <= 1'b0;
            uv3_flag_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            // Sticky; a read clears only once the level has recovered
            uv1_flag_reg <= uv1_live | (uv1_flag_reg & ~rd_st1);
            uv2_flag_reg <= uv2_live | (uv2_flag_reg & ~rd_st1);
            uv3_flag_reg <= uv3_live | (uv3_flag_reg & ~rd_st1);
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ctrl_reg <= uv_stall_pkg::CTRL_RESET;
        else if (ce_i && wr_ctrl)
            ctrl_reg <= wdata_i[uv_stall_pkg::CTRL_WIDTH-1:0];
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            motor_en_reg <= 1'b0;
        else if (ce_i)
        begin
            if (uv3_live || uv3_flag_reg)
                motor_en_reg <= 1'b0;
            else if (wr_ctrl)
                motor_en_reg <= wdata_i[uv_stall_pkg::CTRL_MOTOR_EN_BIT];
        end
    end

    assign motor_enable_o = motor_en_reg;

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            limits_reg <= uv_stall_pkg::LIMITS_RESET;
        else if (ce_i && wr_limits)
            limits_reg <= wdata_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Step masking and lost-step counter

    logic       masking;
    logic       lost_flag_reg;
    logic [6:0] lost_count_reg;
    logic       step_lock_reg;
    logic       stall_flag_reg;

    assign masking = (uv2_live & ctrl_reg[uv_stall_pkg::CTRL_L2_MASK_BIT])
                   | (uv3_live & ctrl_reg[uv_stall_pkg::CTRL_L3_MASK_BIT]);

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            lost_flag_reg <= 1'b0;
        else if (ce_i)
            lost_flag_reg <= (step_edge & masking) | (lost_flag_reg & ~rd_st1);
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            lost_count_reg <= 7'h00;
        else if (ce_i)
        begin
            // Only masked step edges and status-4 reads move the count; direction never does
            if (step_edge && masking)
            begin
                if (rd_st4)
                    lost_count_reg <= 7'h01;
                else if (lost_count_reg != uv_stall_pkg::LOST_MAX)
                    lost_count_reg <= lost_count_reg + 7'h01;
            end
            else if (rd_st4)
                lost_count_reg <= 7'h00;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            step_exec_o <= 1'b0;
        else if (ce_i)
            step_exec_o <= step_edge & ~masking & ~step_lock_reg & ~stall_flag_reg;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Zero-crossing phase and timeout

    logic       zc_d_reg;
    logic [9:0] tick_cnt_reg;
    logic       timed_out_reg;
    logic       timeout_hit;
    logic       phase_end;
    logic       meas_en;
    logic       accept;

    assign meas_en     = measured_speed_i <= speed_limit;
    assign timeout_hit = zero_cross_i & ~timed_out_reg & (timeout != 8'h00)
                       & (tick_cnt_reg >= 10'(timeout * uv_stall_pkg::TICKS_PER_UNIT));
    assign phase_end   = (zc_d_reg & ~zero_cross_i & ~timed_out_reg) | timeout_hit;
    assign accept      = meas_en & zero_cross_i & ~timed_out_reg & sample_valid_i
                       & ~other_coil_pwm_on_i;

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            zc_d_reg      <= 1'b0;
            tick_cnt_reg  <= 10'h000;
            timed_out_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            zc_d_reg <= zero_cross_i;
            if (!zero_cross_i)
            begin
                tick_cnt_reg  <= 10'h000;
                timed_out_reg <= 1'b0;
            end
            else
            begin
                if (pwm_tick_i && tick_cnt_reg != 10'h3FF)
                    tick_cnt_reg <= tick_cnt_reg + 10'h001;
                if (timeout_hit)
                    timed_out_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sample capture and publication

    logic       have_reg;
    logic [4:0] last_code_reg;
    logic       last_sign_reg;
    logic       last_coil_reg;
    logic [4:0] eval_code;
    logic       eval_sign;
    logic       eval_coil;
    logic       eval;
    logic [4:0] code_reg;
    logic       sign_reg;
    logic       coil_reg;
    logic       ready_reg;

    assign eval_code = accept ? sample_code_i : last_code_reg;
    assign eval_sign = accept ? sample_sign_i : last_sign_reg;
    assign eval_coil = accept ? sample_coil_i : last_coil_reg;
    assign eval      = phase_end & (have_reg | accept) & meas_en;

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            have_reg      <= 1'b0;
            last_code_reg <= 5'h00;
            last_sign_reg <= 1'b0;
            last_coil_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            have_reg <= accept & ~phase_end | have_reg & ~phase_end;
            if (accept)
            begin
                last_code_reg <= sample_code_i;
                last_sign_reg <= sample_sign_i;
                last_coil_reg <= sample_coil_i;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            code_reg <= 5'h00;
            sign_reg <= 1'b0;
            coil_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            if (enhanced && accept)
            begin
                code_reg <= sample_code_i;
                sign_reg <= sample_sign_i;
                coil_reg <= sample_coil_i;
            end
            else if (!enhanced && eval)
            begin
                code_reg <= eval_code;
                sign_reg <= eval_sign;
                coil_reg <= eval_coil;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ready_reg <= 1'b0;
        else if (ce_i)
            ready_reg <= (enhanced ? accept : eval) | (ready_reg & ~rd_st4);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Blocked-rotor and hold-motion detection

    logic       below;
    logic [1:0] low_cnt_reg;
    logic       run_hit;
    logic       hold_hit;

    assign below    = eval_code[4:1] < stall_thr;
    assign run_hit  = eval & run_mode_i & (stall_thr != 4'h0) & below
                    & (low_cnt_reg == 2'(uv_stall_pkg::STALL_RUNS - 2'h1));
    assign hold_hit = eval & ~run_mode_i & hold_full_step_i & ~below
                    & (hold_current_setting_i != 4'h0) & (stall_thr != 4'h0);

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            low_cnt_reg <= 2'h0;
        else if (ce_i && eval)
        begin
            if (!run_mode_i || !below || run_hit)
                low_cnt_reg <= 2'h0;
            else
                low_cnt_reg <= low_cnt_reg + 2'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            stall_flag_reg <= 1'b0;
        else if (ce_i)
            stall_flag_reg <= run_hit | hold_hit | (stall_flag_reg & ~rd_st1);
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            step_lock_reg <= 1'b0;
        else if (ce_i)
        begin
            if (rd_st1 && stall_flag_reg && !run_hit && !hold_hit)
                step_lock_reg <= 1'b1;
            else if (dir_change)
                step_lock_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            stall_back_step_o <= 1'b0;
        else if (ce_i)
            stall_back_step_o <= run_hit;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Error line and read data

    logic err_any;

    assign err_any = (uv1_flag_reg & ctrl_reg[uv_stall_pkg::CTRL_L1_IRQ_BIT])
                   | (uv2_flag_reg & ctrl_reg[uv_stall_pkg::CTRL_L2_IRQ_BIT])
                   | (uv3_flag_reg & ctrl_reg[uv_stall_pkg::CTRL_L3_IRQ_BIT])
                   | lost_flag_reg | stall_flag_reg;

    assign error_line_n_o = 1'b0;

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            error_line_oe_o <= 1'b0;
        else if (ce_i)
            error_line_oe_o <= err_any;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rdata_o <= 32'h0000_0000;
        else if (ce_i)
        begin
            rdata_o <= 32'h0000_0000;
            if (rd_i && addr_i == uv_stall_pkg::CTRL_OFFSET)
                rdata_o <= {25'h0, ctrl_reg[6:1], motor_en_reg};
            else if (rd_i && addr_i == uv_stall_pkg::LIMITS_OFFSET)
                rdata_o <= limits_reg;
            else if (rd_st1)
                rdata_o <= {26'h0, step_lock_reg, lost_flag_reg, uv3_flag_reg,
                            uv2_flag_reg, uv1_flag_reg, stall_flag_reg};
            else if (rd_st4)
                rdata_o <= {17'h0, lost_count_reg, ready_reg, coil_reg, sign_reg, code_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    a_lost_saturate: assert property (
        ce_i && lost_count_reg == 7'h7F && !rd_st4 |=> lost_count_reg == 7'h7F)
        else $error("lost-step counter left its maximum");

    a_lost_count_step: assert property (
        ce_i && step_edge && masking && !rd_st4 && lost_count_reg != 7'h7F
        |=> lost_count_reg == $past(lost_count_reg) + 7'h01)
        else $error("masked step not counted");

    a_lost_no_step: assert property (
        ce_i && !step_edge && !rd_st4 |=> $stable(lost_count_reg))
        else $error("lost-step counter moved without a step");

    a_uv3_motor_off: assert property (
        ce_i && uv3_live |=> !motor_en_reg)
        else $error("motor enable kept under level three");

    a_enable_gate: assert property (
        ce_i && uv3_flag_reg |=> !motor_en_reg)
        else $error("motor enabled while level-three flag set");

    a_error_follows: assert property (
        ce_i |=> error_line_oe_o == $past(err_any))
        else $error("error line does not follow its sources");

    a_thr_zero_off: assert property (
        ce_i && stall_thr == 4'h0 && !stall_flag_reg |=> !stall_flag_reg)
        else $error("blocked flag set with detection disabled");

    a_back_step: assert property (
        $rose(stall_back_step_o) |-> stall_flag_reg ##1 error_line_oe_o && !stall_back_step_o)
        else $error("back step without flag or longer than one cycle");

    a_discard_hold: assert property (
        ce_i && enhanced && zero_cross_i && !accept && !(!enhanced)
        |=> $stable(code_reg))
        else $error("discarded sample changed the code");

    a_lock_blocks: assert property (
        ce_i && step_lock_reg |=> !step_exec_o)
        else $error("step executed while waiting for direction change");

    a_stall_clear: assert property (
        ce_i && rd_st1 && !run_hit && !hold_hit |=> !stall_flag_reg)
        else $error("status read did not clear blocked flag");

endmodule : undervoltage_and_stall_monitor

// ===== error_line_mcu_model.sv
// Controller-side view of the shared open-drain error line
`timescale 1ns/100ps
module error_line_mcu_model (
    // From the monitor
    input  wire logic err_oe_i,
    input  wire logic err_val_i,
    // Level seen by the controller
    output logic      err_line_o
);
    // Pull-up holds the line high unless the monitor drives it
    assign err_line_o = err_oe_i ? err_val_i : 1'b1;
endmodule : error_line_mcu_model

// ===== tb.sv
// Self-checking bench for the under-voltage and blocked-rotor monitor
`timescale 1ns/100ps
module tb;
    localparam logic [7:0] A_CT = uv_stall_pkg::CTRL_OFFSET;
    localparam logic [7:0] A_LM = uv_stall_pkg::LIMITS_OFFSET;
    localparam logic [7:0] A_S1 = uv_stall_pkg::STATUS1_OFFSET;
    localparam logic [7:0] A_S4 = uv_stall_pkg::STATUS4_OFFSET;
    logic        clk = 0, rst_n = 0, wr = 0, rd = 0, l1 = 0, l2 = 0, l3 = 0;
    logic        stp = 0, dir = 0, zc = 0, sv = 0, sgn = 0, coil = 0, opwm = 0;
    logic [7:0]  addr = 8'h00, speed = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [4:0]  code = 5'h00;
    logic [3:0]  idx;
    logic        exec, back, men, ev, eoe, eline;
    logic        run = 1, hfs = 0, pt = 0, ce = 1;
    logic [3:0]  ih = 4'h1;
    int          n_mismatch = 0, tests_run = 0, n_exec = 0, n_back = 0, e;
    always #5 clk = ~clk;
    always @(posedge clk) n_exec += (exec === 1'b1);
    always @(posedge clk) n_back += (back === 1'b1);
    undervoltage_and_stall_monitor dut (.core_clk_i(clk), .arst_n_i(rst_n), .ce_i(ce),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .level1_supply_low_i(l1), .level2_supply_low_i(l2), .level3_supply_low_i(l3),
        .undervolt_threshold_index_o(idx), .step_pulse_i(stp), .direction_i(dir),
        .step_exec_o(exec), .stall_back_step_o(back), .run_mode_i(run),
        .hold_full_step_i(hfs), .hold_current_setting_i(ih), .measured_speed_i(speed),
        .pwm_tick_i(pt), .zero_cross_i(zc), .sample_valid_i(sv), .sample_code_i(code),
        .sample_sign_i(sgn), .sample_coil_i(coil), .other_coil_pwm_on_i(opwm),
        .motor_enable_o(men), .error_line_n_o(ev), .error_line_oe_o(eoe));
    error_line_mcu_model mcu (.err_oe_i(eoe), .err_val_i(ev), .err_line_o(eline));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        tests_run++;
        if (s !== x)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, x);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    task automatic step_pin();
        @(posedge clk) stp <= 1'b1;
        cyc(4);
        stp <= 1'b0;
        cyc(4);
    endtask : step_pin
    task automatic sample(input logic [4:0] c, input logic s, input logic k, input logic o);
        @(posedge clk);
        zc   <= 1'b1;
        sv   <= 1'b1;
        code <= c;
        sgn  <= s;
        coil <= k;
        opwm <= o;
        @(posedge clk);
        sv   <= 1'b0;
        opwm <= 1'b0;
    endtask : sample
    task automatic phase_end();
        @(posedge clk) zc <= 1'b0;
        cyc(3);
    endtask : phase_end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #100us;
        n_mismatch++;
        stop_test();
    end
    initial
    begin
        cyc(3);
        rst_n <= 1'b1;
        rd_reg(A_CT); chk(v, 32'h0);
        wr_reg(A_LM, 32'h0000_000B); rd_reg(A_LM); chk(v, 32'hB); chk(idx, 4'hB);
        // Level one: flag only until its enable is set
        l1 <= 1'b1; cyc(6); chk(eline, 1'b1);
        rd_reg(A_S1); chk(v[1], 1'b1);
        wr_reg(A_CT, 32'h4); cyc(3); chk(eline, 1'b0);
        l1 <= 1'b0; wr_reg(A_CT, 32'h0); cyc(4); rd_reg(A_S1); cyc(3); chk(eline, 1'b1);
        // Level three drops the motor and blocks re-enable while flagged
        wr_reg(A_CT, 32'h1); cyc(1); chk(men, 1'b1);
        l3 <= 1'b1; cyc(6); chk(men, 1'b0);
        wr_reg(A_CT, 32'h1); l3 <= 1'b0; cyc(6); chk(men, 1'b0);
        rd_reg(A_S1); chk(v[3], 1'b1); wr_reg(A_CT, 32'h1); cyc(1); chk(men, 1'b1);
        // Masked steps are counted as lost, direction flips ignored
        wr_reg(A_CT, 32'h10); l2 <= 1'b1; cyc(4); rd_reg(A_S4); e = n_exec;
        repeat (5) begin dir <= ~dir; step_pin(); end
        rd_reg(A_S4); chk(v[14:8], 7'h05);
        repeat (130) step_pin();
        rd_reg(A_S4); chk(v[14:8], 7'h7F); chk(n_exec, e); chk(eline, 1'b0);
        l2 <= 1'b0; wr_reg(A_CT, 32'h0); cyc(3); rd_reg(A_S1); chk(v[4], 1'b1);
        step_pin(); chk(n_exec, e + 1);
        // Zero threshold: low samples never stall
        repeat (2) begin sample(5'h00, 0, 0, 0); phase_end(); end
        rd_reg(A_S1); chk(v[0], 1'b0); chk(n_back, 0);
        // Normal mode: nothing until phase end, discarded sample ignored; enhanced mode publishes at once, not above the speed limit
        rd_reg(A_S4); sample(5'h11, 0, 0, 0); rd_reg(A_S4); chk(v[7:0], 8'h00);
        sample(5'h16, 1, 1, 0); sample(5'h1F, 0, 0, 1); phase_end();
        rd_reg(A_S4); chk(v[7:0], 8'hF6);
        wr_reg(A_CT, 32'h2); sample(5'h09, 0, 0, 0); rd_reg(A_S4); chk(v[7:0], 8'h89);
        phase_end(); speed <= 8'h01; rd_reg(A_S4); sample(5'h0A, 0, 0, 0); phase_end();
        rd_reg(A_S4); chk(v[7], 1'b0); speed <= 8'h00;
        // Blocked rotor on two low crossings, then step lock
        wr_reg(A_CT, 32'h0); wr_reg(A_LM, 32'h0000_0400);
        repeat (2) begin sample(5'h04, 0, 0, 0); phase_end(); end
        for (int i = 0; i < 20 && n_back == 0; i++) cyc(1);
        chk(n_back, 1); cyc(2); chk(eline, 1'b0);
        rd_reg(A_S1); chk(v[0], 1'b1); cyc(3); chk(eline, 1'b1);
        e = n_exec; step_pin(); chk(n_exec, e);
        dir <= ~dir; cyc(4); step_pin(); chk(n_exec, e + 1);
        // Timeout forces the phase end; later samples of that phase are ignored
        wr_reg(A_LM, 32'h0001_0400); sample(5'h0B, 1, 0, 0);
        pt <= 1'b1; cyc(4); pt <= 1'b0;
        rd_reg(A_S4); chk(v[7:0], 8'hAB);
        sample(5'h1C, 0, 0, 0); phase_end(); rd_reg(A_S4); chk(v[7:0], 8'h2B);
        // A write with the clock enable low is lost
        ce <= 1'b0; wr_reg(A_LM, 32'h0); ce <= 1'b1; rd_reg(A_LM); chk(v, 32'h0001_0400);
        // Hold at a full step: a high code flags motion, not with zero hold current
        run <= 1'b0; hfs <= 1'b1; sample(5'h0A, 0, 0, 0); phase_end();
        chk(eline, 1'b0);
        rd_reg(A_S1); chk(v[0], 1'b1); chk(n_back, 1); ih <= 4'h0;
        sample(5'h0A, 0, 0, 0); phase_end(); rd_reg(A_S1); chk(v[0], 1'b0);
        stop_test();
    end
endmodule : tb
